// file: hdl/ocss_pkg.sv
// package for the output clock source and sync block: offsets, fields, codes, reset values
// assumes byte-wide registers at their printed offsets on a plain strobe register port
package ocss_pkg;

   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [15:0] OCSS_ADDR_SYNC_LOW = 16'h00A8;
   localparam logic [15:0] OCSS_ADDR_SEL45 = 16'h00A9;
   localparam logic [15:0] OCSS_ADDR_SEL67 = 16'h00AA;
   localparam logic [15:0] OCSS_ADDR_RSVD = 16'h00AB;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int OCSS_POS_LOW_SEL = 0;
   localparam int OCSS_POS_SYNC0 = 4;
   localparam int OCSS_POS_SYNC1 = 5;
   localparam int OCSS_POS_SEL_EVEN = 0;
   localparam int OCSS_POS_SEL_ODD = 4;

   // ------------------------------------------------------------
   // wide source codes for outputs four to seven
   // ------------------------------------------------------------
   localparam logic [2:0] OCSS_SRC_LOOP0 = 3'h0;
   localparam logic [2:0] OCSS_SRC_LOOP1 = 3'h1;
   localparam logic [2:0] OCSS_SRC_OUT2 = 3'h2;
   localparam logic [2:0] OCSS_SRC_OUT3 = 3'h3;
   localparam logic [2:0] OCSS_SRC_REF0 = 3'h4;
   localparam logic [2:0] OCSS_SRC_REF1 = 3'h5;
   localparam logic [2:0] OCSS_SRC_RSVD = 3'h6;
   localparam logic [2:0] OCSS_SRC_XTAL = 3'h7;

   // ------------------------------------------------------------
   // values after reset
   // ------------------------------------------------------------
   localparam logic [3:0] OCSS_RST_LOW_SEL = 4'hA;
   localparam logic OCSS_RST_SYNC = 1'b0;
   localparam logic [2:0] OCSS_RST_SEL4 = 3'h0;
   localparam logic [2:0] OCSS_RST_SEL5 = 3'h2;
   localparam logic [2:0] OCSS_RST_SEL6 = 3'h0;
   localparam logic [2:0] OCSS_RST_SEL7 = 3'h5;
   localparam logic [7:0] OCSS_READ_RSVD = 8'h00;

endpackage

// file: hdl/ocss_src_decode.sv
// decoder of one output's source code into the source it really runs from
// assumes the outputs two and three decode is supplied by the caller
`timescale 1ns/1ps
module ocss_src_decode (
   input wire logic [2:0] code,
   input wire logic out2_loop0,
   input wire logic out2_loop1,
   input wire logic out3_loop0,
   input wire logic out3_loop1,
   output logic from_loop0,
   output logic from_loop1,
   output logic from_ref0,
   output logic from_ref1,
   output logic from_xtal,
   output logic is_rsvd
);

   // a cascaded output inherits the loop of the output it taps
   always_comb begin
      from_loop0 = 1'b0;
      from_loop1 = 1'b0;
      from_ref0 = 1'b0;
      from_ref1 = 1'b0;
      from_xtal = 1'b0;
      is_rsvd = 1'b0;
      case (code)
         ocss_pkg::OCSS_SRC_LOOP0: from_loop0 = 1'b1;
         ocss_pkg::OCSS_SRC_LOOP1: from_loop1 = 1'b1;
         ocss_pkg::OCSS_SRC_OUT2: begin
            from_loop0 = out2_loop0;
            from_loop1 = out2_loop1;
         end
         ocss_pkg::OCSS_SRC_OUT3: begin
            from_loop0 = out3_loop0;
            from_loop1 = out3_loop1;
         end
         ocss_pkg::OCSS_SRC_REF0: from_ref0 = 1'b1;
         ocss_pkg::OCSS_SRC_REF1: from_ref1 = 1'b1;
         ocss_pkg::OCSS_SRC_XTAL: from_xtal = 1'b1;
         default: is_rsvd = 1'b1;
      endcase
   end

endmodule

// file: hdl/ocss_top.sv
// output clock source selection and per-loop output divider sync
// assumes a byte register port on clk; real clock muxes sit outside and follow the selects
//
// Function
// [R1] first loop sync bit high holds every divider fed from the first loop in reset
// [R2] first loop sync bit falling releases all those dividers on the same edge
// [R3] releasing a sync bit clears coarse phase adjust of every affected output
// [R4] second loop sync bit holds and releases its dividers the same way
// [R5] outputs zero to three: select 0 takes first loop, 1 takes second loop
// [R6] output one select is 1 after reset
// [R7] output two select is 0 after reset
// [R8] output four three-bit code set as listed, reset value 000
// [R9] software must not write reserved code 110 to output four select
// [R10] software must not pick an input reference running above its frequency limit
// [R11] output five uses same code set, reset value 010
// [R12] output seven uses same code set, reset value 101
// [R13] output six uses same code set, reset value 000
`timescale 1ns/1ps
module ocss_top #(
   parameter int NUM_OUT = 8
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic [NUM_OUT-1:0] out_from_loop0,
   output logic [NUM_OUT-1:0] out_from_loop1,
   output logic [NUM_OUT-1:0] out_from_ref0,
   output logic [NUM_OUT-1:0] out_from_ref1,
   output logic [NUM_OUT-1:0] out_from_xtal,
   output logic [NUM_OUT-1:0] out_src_rsvd,
   output logic [NUM_OUT-1:0] div_hold,
   output logic [NUM_OUT-1:0] coarse_clear
);

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [3:0] low_sel_q;
   logic sync0_q;
   logic sync1_q;
   logic [2:0] sel4_q;
   logic [2:0] sel5_q;
   logic [2:0] sel6_q;
   logic [2:0] sel7_q;
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         low_sel_q <= ocss_pkg::OCSS_RST_LOW_SEL; // R5 R6 R7
         sync0_q <= ocss_pkg::OCSS_RST_SYNC;
         sync1_q <= ocss_pkg::OCSS_RST_SYNC;
      end else if (reg_wr && reg_addr == ocss_pkg::OCSS_ADDR_SYNC_LOW) begin
         low_sel_q <= reg_wdata[ocss_pkg::OCSS_POS_LOW_SEL +: 4];
         sync0_q <= reg_wdata[ocss_pkg::OCSS_POS_SYNC0];
         sync1_q <= reg_wdata[ocss_pkg::OCSS_POS_SYNC1];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sel4_q <= ocss_pkg::OCSS_RST_SEL4; // R8
         sel5_q <= ocss_pkg::OCSS_RST_SEL5; // R11
      end else if (reg_wr && reg_addr == ocss_pkg::OCSS_ADDR_SEL45) begin
         // reserved code is stored as written; it selects nothing and is flagged
         sel4_q <= reg_wdata[ocss_pkg::OCSS_POS_SEL_EVEN +: 3];
         sel5_q <= reg_wdata[ocss_pkg::OCSS_POS_SEL_ODD +: 3];
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sel6_q <= ocss_pkg::OCSS_RST_SEL6; // R13
         sel7_q <= ocss_pkg::OCSS_RST_SEL7; // R12
      end else if (reg_wr && reg_addr == ocss_pkg::OCSS_ADDR_SEL67) begin
         sel6_q <= reg_wdata[ocss_pkg::OCSS_POS_SEL_EVEN +: 3];
         sel7_q <= reg_wdata[ocss_pkg::OCSS_POS_SEL_ODD +: 3];
      end
   end

   // reserved bits and unmapped offsets read as zero
   always_comb begin
      rdata_d = ocss_pkg::OCSS_READ_RSVD;
      case (reg_addr)
         ocss_pkg::OCSS_ADDR_SYNC_LOW: begin
            rdata_d[ocss_pkg::OCSS_POS_LOW_SEL +: 4] = low_sel_q;
            rdata_d[ocss_pkg::OCSS_POS_SYNC0] = sync0_q;
            rdata_d[ocss_pkg::OCSS_POS_SYNC1] = sync1_q;
         end
         ocss_pkg::OCSS_ADDR_SEL45: begin
            rdata_d[ocss_pkg::OCSS_POS_SEL_EVEN +: 3] = sel4_q;
            rdata_d[ocss_pkg::OCSS_POS_SEL_ODD +: 3] = sel5_q;
         end
         ocss_pkg::OCSS_ADDR_SEL67: begin
            rdata_d[ocss_pkg::OCSS_POS_SEL_EVEN +: 3] = sel6_q;
            rdata_d[ocss_pkg::OCSS_POS_SEL_ODD +: 3] = sel7_q;
         end
         default: rdata_d = ocss_pkg::OCSS_READ_RSVD;
      endcase
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rdata_q <= ocss_pkg::OCSS_READ_RSVD;
      end else if (reg_rd) begin
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ------------------------------------------------------------
   // source decode
   // ------------------------------------------------------------
   logic [2:0] code [NUM_OUT];
   logic [NUM_OUT-1:0] use0;
   logic [NUM_OUT-1:0] use1;
   logic [NUM_OUT-1:0] use_ref0;
   logic [NUM_OUT-1:0] use_ref1;
   logic [NUM_OUT-1:0] use_xtal;
   logic [NUM_OUT-1:0] use_rsvd;

   assign code[4] = sel4_q;
   assign code[5] = sel5_q;
   assign code[6] = sel6_q;
   assign code[7] = sel7_q;

   // outputs two and three only ever take a loop, so cascading cannot form a loop
   genvar gi;
   generate
      for (gi = 0; gi < NUM_OUT; gi++) begin : g_dec
         if (gi < 4) begin : g_low
            assign code[gi] = {2'b00, low_sel_q[gi]}; // R5
         end
         // cascade taps read the low selects directly, so no false comb loop through use0/use1
         ocss_src_decode u_dec (
            .code(code[gi]),
            .out2_loop0(~low_sel_q[2]),
            .out2_loop1(low_sel_q[2]),
            .out3_loop0(~low_sel_q[3]),
            .out3_loop1(low_sel_q[3]),
            .from_loop0(use0[gi]),
            .from_loop1(use1[gi]),
            .from_ref0(use_ref0[gi]),
            .from_ref1(use_ref1[gi]),
            .from_xtal(use_xtal[gi]),
            .is_rsvd(use_rsvd[gi])
         );
      end
   endgenerate

   logic [NUM_OUT-1:0] loop0_q;
   logic [NUM_OUT-1:0] loop1_q;
   logic [NUM_OUT-1:0] ref0_q;
   logic [NUM_OUT-1:0] ref1_q;
   logic [NUM_OUT-1:0] xtal_q;
   logic [NUM_OUT-1:0] rsvd_q;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         loop0_q <= '0;
         loop1_q <= '0;
         ref0_q <= '0;
         ref1_q <= '0;
         xtal_q <= '0;
         rsvd_q <= '0;
      end else begin
         loop0_q <= use0; // R5 R8
         loop1_q <= use1;
         ref0_q <= use_ref0;
         ref1_q <= use_ref1;
         xtal_q <= use_xtal;
         rsvd_q <= use_rsvd;
      end
   end

   assign out_from_loop0 = loop0_q;
   assign out_from_loop1 = loop1_q;
   assign out_from_ref0 = ref0_q;
   assign out_from_ref1 = ref1_q;
   assign out_from_xtal = xtal_q;
   assign out_src_rsvd = rsvd_q;

   // ------------------------------------------------------------
   // divider sync
   // ------------------------------------------------------------
   logic sync0_prev_q;
   logic sync1_prev_q;
   logic fall0;
   logic fall1;
   logic [NUM_OUT-1:0] hold_q;
   logic [NUM_OUT-1:0] clear_q;

   assign fall0 = sync0_prev_q & ~sync0_q;
   assign fall1 = sync1_prev_q & ~sync1_q;

   // hold and clear come from one registered stage, so all dividers leave reset on one edge
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sync0_prev_q <= ocss_pkg::OCSS_RST_SYNC;
         sync1_prev_q <= ocss_pkg::OCSS_RST_SYNC;
         hold_q <= '0;
         clear_q <= '0;
      end else begin
         sync0_prev_q <= sync0_q;
         sync1_prev_q <= sync1_q;
         hold_q <= ({NUM_OUT{sync0_q}} & use0) | ({NUM_OUT{sync1_q}} & use1); // R1 R2 R4
         clear_q <= ({NUM_OUT{fall0}} & use0) | ({NUM_OUT{fall1}} & use1); // R3 R4
      end
   end

   assign div_hold = hold_q;
   assign coarse_clear = clear_q;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   sequence s_release0;
      $fell(sync0_q) && !sync1_q && !sync1_prev_q;
   endsequence

   chk_hold_loop0: assert property (@(posedge clk) disable iff (reset) // R1
      sync0_q && !sync1_q |=> div_hold == $past(use0))
      else $error("first loop dividers not held");

   chk_release_loop0: assert property (@(posedge clk) disable iff (reset) // R2
      s_release0 |=> div_hold == '0)
      else $error("first loop dividers not released together");

   chk_coarse_clear: assert property (@(posedge clk) disable iff (reset) // R3
      s_release0 |=> coarse_clear == $past(use0) ##1 coarse_clear == '0)
      else $error("coarse clear pulse wrong on release");

   chk_hold_loop1: assert property (@(posedge clk) disable iff (reset) // R4
      sync1_q && !sync0_q |=> div_hold == $past(use1) ##0 (coarse_clear & $past(use1)) == '0)
      else $error("second loop dividers not held");

   chk_low_route: assert property (@(posedge clk) disable iff (reset) // R5
      1'b1 |=> out_from_loop1[3:0] == $past(low_sel_q) && out_from_loop0[3:0] == ~$past(low_sel_q))
      else $error("low output routing wrong");

   chk_reset_out1: assert property (@(posedge clk) disable iff (1'b0) // R6
      reset |-> low_sel_q[1] == 1'b1)
      else $error("output one select not 1 in reset");

   chk_reset_out2: assert property (@(posedge clk) disable iff (1'b0) // R7
      reset |-> low_sel_q[2] == 1'b0)
      else $error("output two select not 0 in reset");

   chk_out4_decode: assert property (@(posedge clk) disable iff (reset) // R8
      sel4_q == ocss_pkg::OCSS_SRC_XTAL |=> out_from_xtal[4] && !out_from_loop0[4])
      else $error("output four crystal decode wrong");

   chk_out5_cascade: assert property (@(posedge clk) disable iff (1'b0) // R11
      reset |-> sel5_q == 3'h2)
      else $error("output five reset code wrong");

   chk_out7_reset: assert property (@(posedge clk) disable iff (1'b0) // R12
      reset |-> sel7_q == 3'h5)
      else $error("output seven reset code wrong");

   chk_out6_reset: assert property (@(posedge clk) disable iff (1'b0) // R13
      reset |-> sel6_q == 3'h0 && sel4_q == 3'h0)
      else $error("output six or four reset code wrong");

endmodule

// file: testbench/ocss_top_tb.sv
// self-checking bench for the output clock source and sync block
// assumes the strobe byte register port and registered outputs of ocss_top
`timescale 1ns/1ps
module ocss_top_tb;
   logic clk;
   logic reset;
   logic [15:0] reg_addr;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_wdata;
   logic [7:0] reg_rdata;
   logic [7:0] out_from_loop0;
   logic [7:0] out_from_loop1;
   logic [7:0] out_from_ref0;
   logic [7:0] out_from_ref1;
   logic [7:0] out_from_xtal;
   logic [7:0] out_src_rsvd;
   logic [7:0] div_hold;
   logic [7:0] coarse_clear;
   int failures;
   int checks_done;

   ocss_top #(.NUM_OUT(8)) dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .out_from_loop0(out_from_loop0), .out_from_loop1(out_from_loop1),
      .out_from_ref0(out_from_ref0), .out_from_ref1(out_from_ref1),
      .out_from_xtal(out_from_xtal), .out_src_rsvd(out_src_rsvd),
      .div_hold(div_hold), .coarse_clear(coarse_clear));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data is registered, so it is looked at just after the taking edge
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp, input string what);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp, what);
   endtask

   // decode outputs follow a write by one edge
   task automatic settle();
      @(posedge clk);
      #1;
   endtask

   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset_values();
      rd_chk(ocss_pkg::OCSS_ADDR_SYNC_LOW, 8'h0A, "low selects after reset");
      rd_chk(ocss_pkg::OCSS_ADDR_SEL45, 8'h20, "q4 q5 selects after reset");
      rd_chk(ocss_pkg::OCSS_ADDR_SEL67, 8'h50, "q6 q7 selects after reset");
      chk(out_from_loop0, 8'h75, "first loop map after reset");
      chk(out_from_loop1, 8'h0A, "second loop map after reset");
      chk(out_from_ref1, 8'h80, "ref one map after reset");
      chk(div_hold, 8'h00, "no hold after reset");
      $display("test reset_values done");
   endtask

   // every legal q4 code; q2 runs from the first loop and q3 from the second
   // the reserved code is never written, software must keep off it
   task automatic t_q4_codes();
      logic [4:0] exp_tab [8];
      logic [4:0] got;
      exp_tab = '{5'h01, 5'h02, 5'h01, 5'h02, 5'h04, 5'h08, 5'h00, 5'h10};
      for (int c = 0; c < 8; c++) begin
         if (c == 6) continue;
         wr(ocss_pkg::OCSS_ADDR_SEL45, 8'(c));
         settle();
         got = {out_from_xtal[4], out_from_ref1[4], out_from_ref0[4],
                out_from_loop1[4], out_from_loop0[4]};
         chk(8'(got), 8'(exp_tab[c]), "q4 source decode");
         chk(8'(out_src_rsvd[4]), 8'h00, "q4 reserved flag");
         rd_chk(ocss_pkg::OCSS_ADDR_SEL45, 8'(c), "q4 select readback");
      end
      wr(ocss_pkg::OCSS_ADDR_SEL45, 8'h20);
      $display("test q4_codes done");
   endtask

   task automatic t_low_and_wide();
      wr(ocss_pkg::OCSS_ADDR_SYNC_LOW, 8'h05);
      // reference zero is taken to run inside its frequency limit here
      wr(ocss_pkg::OCSS_ADDR_SEL67, 8'h74);
      settle();
      chk(out_from_loop0 & 8'h0F, 8'h0A, "low outputs on first loop");
      chk(out_from_loop1 & 8'h0F, 8'h05, "low outputs on second loop");
      chk(8'(out_from_loop1[5]), 8'h01, "q5 cascade follows q2");
      chk(out_from_ref0, 8'h40, "q6 on ref zero");
      chk(out_from_xtal, 8'h80, "q7 on crystal");
      wr(ocss_pkg::OCSS_ADDR_RSVD, 8'hFF);
      rd_chk(ocss_pkg::OCSS_ADDR_RSVD, 8'h00, "reserved register stays zero");
      rd_chk(16'h0010, 8'h00, "unmapped read is zero");
      wr(ocss_pkg::OCSS_ADDR_SYNC_LOW, 8'h0A);
      wr(ocss_pkg::OCSS_ADDR_SEL67, 8'h50);
      $display("test low_and_wide done");
   endtask

   // hold while set, then a common release with a one-cycle coarse clear
   task automatic t_sync(input logic [7:0] set_val, input logic [7:0] mask);
      wr(ocss_pkg::OCSS_ADDR_SYNC_LOW, set_val);
      settle();
      chk(div_hold, mask, "dividers held");
      chk(coarse_clear, 8'h00, "no clear while held");
      repeat (3) @(posedge clk);
      #1;
      chk(div_hold, mask, "hold persists");
      wr(ocss_pkg::OCSS_ADDR_SYNC_LOW, 8'h0A);
      settle();
      chk(div_hold, 8'h00, "all released together");
      chk(coarse_clear, mask, "coarse cleared on release");
      settle();
      chk(coarse_clear, 8'h00, "coarse clear is one cycle");
      $display("test sync done");
   endtask

   // ------------------------------------------------------------
   // clock, reset, sequence, watchdog
   // ------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      failures = 0;
      checks_done = 0;
      // non-blocking so the asynchronous reset edge is seen by every register at time zero
      reset <= 1'b1;
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
      repeat (20) @(posedge clk);
      reset <= 1'b0;
      settle();
      t_reset_values();
      t_q4_codes();
      t_low_and_wide();
      t_sync(8'h1A, 8'h75);
      t_sync(8'h2A, 8'h0A);
      t_sync(8'h3A, 8'h7F);
      final_report();
   end

   // the whole sequence needs about 110 cycles
   initial begin
      #50000;
      failures++;
      $display("CHECK FAILED at %0t: watchdog expired", $time);
      final_report();
   end
endmodule
